// ---- bench/iopc_host_model.sv ----
`timescale 1ns/1ps
module iopc_host_model (
    input wire [7:0] dev_d_i, input wire dev_oe_n_i, input wire [7:0] wr_d_i,
    input wire irq_i, input wire irq_oe_n_i,
    output wire [7:0] bus_o, output wire irq_n_o
);
    assign bus_o = dev_oe_n_i ? wr_d_i : dev_d_i;
    // Pull-up wins whenever the device lets go of the shared line
    assign irq_n_o = irq_oe_n_i ? 1'b1 : irq_i;
endmodule // iopc_host_model

// ---- bench/iopc_properties.sv ----
`timescale 1ns/1ps
module iopc_properties (
    input wire clk_i, sys_rst_i, bus_mode_i, chan_a_irq_en_i, chan_b_irq_en_i,
    input wire chan_a_irq_pend_i, chan_b_irq_pend_i, host_rd_en_i,
    input wire [7:0] host_rd_data_i, host_bus_i, host_bus_o, host_wr_data_o,
    input wire host_bus_oe_n_o, chan_a_irq_out_o, chan_a_irq_out_oe_n_o,
    input wire chan_b_irq_out_o, chan_b_irq_out_oe_n_o,
    input wire chan_a_user_out_n_o, chan_b_user_out_n_o
);
    // Synchronisers keep reset values for a few edges after any
    // reset, so history-based checks wait until those drain
    reg [3:0] rst_hist = 4'hf;
    always @(posedge clk_i) rst_hist <= {rst_hist[2:0], sys_rst_i};
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || rst_hist != 4'h0);
    a_user_both: assert property (
        {chan_a_user_out_n_o, chan_b_user_out_n_o} ==
        ~$past({chan_a_irq_en_i, chan_b_irq_en_i})) else $error("user");
    a_oe_a_per: assert property ($past(bus_mode_i, 3) |->
        chan_a_irq_out_oe_n_o == !$past(chan_a_irq_en_i)) else $error("oe a");
    a_oe_b_per: assert property ($past(bus_mode_i, 3) |->
        chan_b_irq_out_oe_n_o == !$past(chan_b_irq_en_i)) else $error("oe b");
    a_pin_a_pend: assert property ($past(bus_mode_i, 3) &&
        $past(chan_a_irq_en_i) |-> chan_a_irq_out_o ==
        $past(chan_a_irq_pend_i)) else $error("pin a");
    a_pin_b_pend: assert property ($past(bus_mode_i, 3) &&
        $past(chan_b_irq_en_i) |-> chan_b_irq_out_o ==
        $past(chan_b_irq_pend_i)) else $error("pin b");
    a_shared_a_od: assert property (!$past(bus_mode_i, 3) |->
        !chan_a_irq_out_o && chan_a_irq_out_oe_n_o ==
        !$past(chan_a_irq_pend_i | chan_b_irq_pend_i)) else $error("shr");
    a_shared_b_off: assert property (!$past(bus_mode_i, 3) |->
        chan_b_irq_out_oe_n_o && !chan_b_irq_out_o) else $error("b used");
    a_bus_rd: assert property ($past(host_rd_en_i) |-> !host_bus_oe_n_o
        && host_bus_o == $past(host_rd_data_i)) else $error("rd");
    a_bus_float: assert property (!$past(host_rd_en_i) |->
        host_bus_oe_n_o) else $error("float");
    a_bus_wr: assert property (
        host_wr_data_o == $past(host_bus_i, 2)) else $error("wr");
endmodule // iopc_properties

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    reg clk_i = 0, sys_rst_i = 1, md = 1, ea = 0, eb = 0, pa = 0, pb = 0;
    reg rd = 0;
    reg [7:0] rdd = 8'h00, wd = 8'h00;
    wire [7:0] bus, bo, wo;
    wire boe, ao, aoe, bp, boe2, ua, ub, irq_n;
    integer num_errors = 0, checks_done = 0, cyc = 0, i;
    iopc_top i_iopc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .bus_mode_i(md), .chan_a_irq_en_i(ea), .chan_b_irq_en_i(eb),
        .chan_a_irq_pend_i(pa), .chan_b_irq_pend_i(pb), .host_rd_en_i(rd),
        .host_rd_data_i(rdd), .host_bus_i(bus), .host_bus_o(bo),
        .host_bus_oe_n_o(boe), .host_wr_data_o(wo), .chan_a_irq_out_o(ao),
        .chan_a_irq_out_oe_n_o(aoe), .chan_b_irq_out_o(bp),
        .chan_b_irq_out_oe_n_o(boe2), .chan_a_user_out_n_o(ua),
        .chan_b_user_out_n_o(ub));
    iopc_host_model i_iopc_host_model (.dev_d_i(bo), .dev_oe_n_i(boe),
        .wr_d_i(wd), .irq_i(ao), .irq_oe_n_i(aoe), .bus_o(bus),
        .irq_n_o(irq_n));
    initial forever #5 clk_i = ~clk_i;
    task conclude;
        if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input [15:0] s, input [15:0] e);
        checks_done = checks_done + 1;
        if (s !== e) begin
            num_errors = num_errors + 1;
            $display("Error %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task step(input integer n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc > 500) begin
            num_errors = num_errors + 1;
            conclude;
        end
    end
    task scen_per_chan;
        for (i = 0; i < 16; i = i + 1) begin
            {ea, pa, eb, pb} = i[3:0];
            step(1);
            chk({aoe, ua, ao & ea}, {!ea, !ea, ea & pa});
            chk({boe2, ub, bp & eb}, {!eb, !eb, eb & pb});
        end
    endtask
    task scen_shared;
        md = 0;
        step(4);
        for (i = 0; i < 4; i = i + 1) begin
            {pa, pb} = i[1:0];
            step(1);
            chk({irq_n, boe2, bp}, {!(pa | pb), 1'b1, 1'b0});
            chk({ua, ub}, {!ea, !eb});
        end
    endtask
    task scen_host_rd;
        rd = 1;
        rdd = 8'ha5;
        step(1);
        chk({boe, bus}, {1'b0, 8'ha5});
    endtask
    task scen_host_wr;
        rd = 0;
        wd = 8'h01;
        step(1);
        chk({boe, bus}, {1'b1, 8'h01});
        step(2);
        chk(wo, 8'h01);
    endtask
    task scen_reset;
        md = 1;
        ea = 1;
        pa = 1;
        sys_rst_i = 1;
        step(4);
        chk({aoe, boe2, ua, ub, ao, bp, boe}, 7'h79);
        chk({bo, wo}, 16'h0000);
        sys_rst_i = 0;
        step(1);
        chk({aoe, ua, ao}, {1'b0, 1'b0, 1'b1});
    endtask
    initial begin
        step(16);
        sys_rst_i = 0;
        scen_per_chan;
        scen_shared;
        scen_host_rd;
        scen_host_wr;
        scen_reset;
        conclude;
    end
endmodule // testbench
bind iopc_top iopc_properties i_iopc_properties (.*);

// ---- src/iopc_chan_out.v ----
`timescale 1ns/1ps
`include "iopc_defines.vh"
// ============================================================
// Per-channel pin stage, next values only; the top registers them
module iopc_chan_out (
    input wire per_chan_i,
    input wire out_en_i,
    input wire irq_pend_i,
    output reg nxt_pin_o,
    output reg nxt_oe_n_o,
    output reg nxt_user_n_o
);
    always @* begin
        nxt_pin_o = irq_pend_i; // R9
        nxt_oe_n_o = `IOPC_OE_OFF;
        nxt_user_n_o = ~out_en_i; // R2 R3 R5 R6
        if (per_chan_i && out_en_i) begin
            nxt_oe_n_o = `IOPC_OE_ON; // R2 R5
        end
    end
endmodule // iopc_chan_out

// ---- src/iopc_defines.vh ----
// How it works
// [R1] Mode select high: pin one is channel A
// [R2] Enable bit set: drive A pin, user low
// [R3] Enable bit clear: float A pin, user high
// [R4] Mode low: pin one shared open-drain, active low
// [R5] Mode high: pin two is channel B
// [R6] B enable clear: float B pin, user high
// [R7] Mode low: pin two unused
// [R8] Eight-bit three-state host bus, bit0 LSB
// [R9] Enabled pin high while channel interrupt pending
`ifndef IOPC_DEFINES_VH
`define IOPC_DEFINES_VH
// ============================================================
// Constants
`define IOPC_DATA_W 8
`define IOPC_MODE_SHARED 1'b0
`define IOPC_OE_ON 1'b0
`define IOPC_OE_OFF 1'b1
`define IOPC_BUS_RST 8'h00
`define IOPC_MODE_RST 1'b1
`define IOPC_PIN_RST 1'b0
`define IOPC_USER_RST 1'b1
`define IOPC_OD_LOW 1'b0
`endif

// ---- src/iopc_top.v ----
`timescale 1ns/1ps
`include "iopc_defines.vh"
// ============================================================
// Interrupt pin and host data bus output stage
module iopc_top #(
    parameter DATA_W = `IOPC_DATA_W
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire bus_mode_i,
    input wire chan_a_irq_en_i,
    input wire chan_b_irq_en_i,
    input wire chan_a_irq_pend_i,
    input wire chan_b_irq_pend_i,
    input wire host_rd_en_i,
    input wire [DATA_W-1:0] host_rd_data_i,
    input wire [DATA_W-1:0] host_bus_i,
    output reg [DATA_W-1:0] host_bus_o,
    output reg host_bus_oe_n_o,
    output reg [DATA_W-1:0] host_wr_data_o,
    output reg chan_a_irq_out_o,
    output reg chan_a_irq_out_oe_n_o,
    output reg chan_b_irq_out_o,
    output reg chan_b_irq_out_oe_n_o,
    output reg chan_a_user_out_n_o,
    output reg chan_b_user_out_n_o
);
    // ========================================================
    // Channel slots; the pin set fixes the count at two
    localparam NUM_CHAN = 2;
    localparam CHAN_A = 0;
    localparam CHAN_B = 1;

    // ========================================================
    // Three-state enable encoding, used by the shared-mode A pin and the host bus
    function oe_n_of;
        input drive;
        begin
            oe_n_of = drive ? `IOPC_OE_ON : `IOPC_OE_OFF;
        end
    endfunction

    // ========================================================
    // Mode pin synchroniser
    // Resets to per-channel mode, the same as an unconnected pin
    reg mode_s1_ff;
    reg mode_ff;
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode_s1_ff <= `IOPC_MODE_RST;
            mode_ff <= `IOPC_MODE_RST;
        end else begin
            mode_s1_ff <= bus_mode_i;
            mode_ff <= mode_s1_ff; // R1 R4
        end
    end

    wire per_chan = (mode_ff != `IOPC_MODE_SHARED);

    // ========================================================
    // Host bus input synchroniser
    // Bits cross one by one, so a byte caught while the host
    // changes it may mix old and new bits for one cycle
    reg [DATA_W-1:0] bus_s1_ff;
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            bus_s1_ff <= `IOPC_BUS_RST;
            host_wr_data_o <= `IOPC_BUS_RST;
        end else begin
            bus_s1_ff <= host_bus_i;
            host_wr_data_o <= bus_s1_ff; // R8
        end
    end

    // ========================================================
    // Per-channel pin stages
    wire [NUM_CHAN-1:0] chan_en;
    wire [NUM_CHAN-1:0] chan_pend;
    wire [NUM_CHAN-1:0] chan_pin;
    wire [NUM_CHAN-1:0] chan_oe_n;
    wire [NUM_CHAN-1:0] chan_user_n;
    assign chan_en = {chan_b_irq_en_i, chan_a_irq_en_i};
    assign chan_pend = {chan_b_irq_pend_i, chan_a_irq_pend_i};

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g = g + 1) begin : g_chan
            iopc_chan_out u_chan (
                .per_chan_i(per_chan),
                .out_en_i(chan_en[g]),
                .irq_pend_i(chan_pend[g]),
                .nxt_pin_o(chan_pin[g]),
                .nxt_oe_n_o(chan_oe_n[g]),
                .nxt_user_n_o(chan_user_n[g])
            );
        end
    endgenerate

    // ========================================================
    // Shared-mode request: any pending channel pulls the line
    wire any_pend = |chan_pend;

    // ========================================================
    // Next pin values
    // Shared mode overrides the channel stages; the pin value is
    // held low so that enabling the driver can only pull down
    reg nxt_a_pin;
    reg nxt_a_oe_n;
    reg nxt_b_pin;
    reg nxt_b_oe_n;
    always @* begin
        nxt_a_pin = chan_pin[CHAN_A]; // R1 R9
        nxt_a_oe_n = chan_oe_n[CHAN_A]; // R2 R3
        nxt_b_pin = chan_pin[CHAN_B]; // R5 R9
        nxt_b_oe_n = chan_oe_n[CHAN_B]; // R5 R6
        if (!per_chan) begin
            nxt_a_pin = `IOPC_OD_LOW; // R4
            nxt_a_oe_n = oe_n_of(any_pend); // R4
            nxt_b_pin = `IOPC_PIN_RST; // R7
            nxt_b_oe_n = `IOPC_OE_OFF; // R7
        end
    end

    // ========================================================
    // Next host bus values
    reg [DATA_W-1:0] nxt_bus;
    reg nxt_bus_oe_n;
    always @* begin
        nxt_bus = host_rd_data_i; // R8
        nxt_bus_oe_n = oe_n_of(host_rd_en_i); // R8
    end

    // ========================================================
    // Output registers, one per pin, so that each reset value
    // stands beside the pin it belongs to; every three-state pin
    // floats and each user output is driven high while reset is held
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            chan_a_irq_out_o <= `IOPC_PIN_RST;
        end else begin
            chan_a_irq_out_o <= nxt_a_pin; // R1 R4 R9
        end
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            chan_a_irq_out_oe_n_o <= `IOPC_OE_OFF;
        end else begin
            chan_a_irq_out_oe_n_o <= nxt_a_oe_n; // R2 R3 R4
        end
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            chan_b_irq_out_o <= `IOPC_PIN_RST;
        end else begin
            chan_b_irq_out_o <= nxt_b_pin; // R5 R7 R9
        end
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            chan_b_irq_out_oe_n_o <= `IOPC_OE_OFF;
        end else begin
            chan_b_irq_out_oe_n_o <= nxt_b_oe_n; // R5 R6 R7
        end
    end

    // User outputs follow the enable bit in both modes, so a
    // board that uses them must leave the interrupt pin alone
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            chan_a_user_out_n_o <= `IOPC_USER_RST;
        end else begin
            chan_a_user_out_n_o <= chan_user_n[CHAN_A]; // R2 R3
        end
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            chan_b_user_out_n_o <= `IOPC_USER_RST;
        end else begin
            chan_b_user_out_n_o <= chan_user_n[CHAN_B]; // R5 R6
        end
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            host_bus_o <= `IOPC_BUS_RST;
        end else begin
            host_bus_o <= nxt_bus; // R8
        end
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            host_bus_oe_n_o <= `IOPC_OE_OFF;
        end else begin
            host_bus_oe_n_o <= nxt_bus_oe_n; // R8
        end
    end
endmodule // iopc_top
